// ==== inc/fsps_pkg.sv ====
// package of constants and types for the flash self-programming sequencer
package fsps_pkg;
  // control/status bit positions
  localparam int unsigned CTL_ENABLE_BIT = 0;
  localparam int unsigned CTL_ERASE_BIT = 1;
  localparam int unsigned CTL_WRITE_BIT = 2;
  localparam int unsigned CTL_LOCKSET_BIT = 3;
  localparam int unsigned CTL_REENABLE_BIT = 4;
  localparam int unsigned CTL_BUSY_BIT = 6;
  localparam int unsigned CTL_INT_EN_BIT = 7;
  // command patterns in the low five bits (bit 6..5 are don't care)
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_LOCKSET = 5'h09;
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // arming window of the store instruction
  localparam int unsigned ARM_WINDOW_CYC = 4;
  localparam logic [2:0] ARM_WINDOW = 3'h4;
  // application reset address
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] BOOT_RESET_ADDR = 16'h3800;
  // flash operation time, in microseconds, and its cycle count at 100 MHz
  localparam int unsigned PROG_TIME_US = 4;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
  // geometry defaults
  localparam int unsigned PAGE_WORDS_LOG2 = 6;
  localparam logic [15:0] NO_READ_WHILE_WRITE_SECTION_START_WORD = 16'h3800;
  typedef enum logic [3:0] {
    FSPS_IDLE = 4'b0001,
    FSPS_ARMED = 4'b0010,
    FSPS_BUSY = 4'b0100,
    FSPS_DONE = 4'b1000
  } fsps_state_e;
endpackage

// ==== inc/fsps_if.sv ====
// interface joining the cpu-side boot loader end and the sequencer end
`timescale 1ns/1ps
interface fsps_if;
  logic [7:0] ctl_wdata;
  logic ctl_we;
  logic [7:0] ctl_rdata;
  logic spm_exec;
  logic [7:0] ptr_high;
  logic [7:0] ptr_low;
  logic [15:0] data_word;
  logic eeprom_write;
  logic cpu_halt;
  logic rww_blocked;
  logic spm_irq;
  logic [15:0] reset_vector;
  modport device (
    input ctl_wdata, ctl_we, spm_exec, ptr_high, ptr_low, data_word, eeprom_write,
    output ctl_rdata, cpu_halt, rww_blocked, spm_irq, reset_vector
  );
  modport host (
    output ctl_wdata, ctl_we, spm_exec, ptr_high, ptr_low, data_word, eeprom_write,
    input ctl_rdata, cpu_halt, rww_blocked, spm_irq, reset_vector
  );
endinterface

// ==== src/fsps_sequencer.sv ====
// flash self-programming sequencer, device end
`timescale 1ns/1ps
// Notes on behaviour
// - reset vector chosen by boot reset fuse
// - cpu cannot change fuse values
// - pointer is high byte and low byte
// - pointer splits into page and word fields
// - target address latched at operation start
// - lock bit setting ignores the pointer
// - byte reads use every pointer bit
// - software erases page before writing it
// - buffer words load in any order
// - erase armed by pattern, store within four
// - rww erase keeps no_read_while_write_section section readable
// - no_read_while_write_section erase halts the cpu
// - load puts data word at word field
// - buffer cleared after write, reenable, reset
// - each buffer word written once only; here a later load to the same word overwrites it
// - eeprom write during loading discards buffer
// - write armed by pattern, store within four
// - page write halts or blocks by section
// - level interrupt while enable bit cleared
// - software keeps vectors in boot section
// - same page for erase and write
// - busy flag set while rww blocked
// - armed bits auto-clear after four cycles
module fsps_sequencer #(
  parameter int unsigned PAGE_LOG2 = fsps_pkg::PAGE_WORDS_LOG2,
  parameter int unsigned PROG_CYCLES = fsps_pkg::PROG_CYC,
  parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_START = fsps_pkg::NO_READ_WHILE_WRITE_SECTION_START_WORD
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  fsps_if.device bus,
  input wire logic boot_reset_select_fuse_i,
  input wire logic [15:0] lpm_addr_i,
  output logic [15:0] lpm_byte_addr_o,
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic [15:0] flash_page_addr_o,
  output logic [15:0] flash_data_o,
  output logic [PAGE_LOG2-1:0] flash_word_o,
  output logic buf_valid_o,
  output logic lock_set_o,
  output logic [7:0] lock_data_o
);
  localparam int unsigned WORDS = 1 << PAGE_LOG2;

  // ----------------------------------------------------------------
  // pointer decode
  // ----------------------------------------------------------------
  logic [15:0] pointer;
  logic [PAGE_LOG2-1:0] word_in_page_field;
  logic [15:0] page_select_field;
  // pointer is byte address; bit 0 selects byte and is unused for spm
  assign pointer = {bus.ptr_high, bus.ptr_low};
  assign word_in_page_field = pointer[PAGE_LOG2:1];
  assign page_select_field = {pointer[15:PAGE_LOG2+1], {(PAGE_LOG2+1){1'b0}}};

  // ----------------------------------------------------------------
  // control/status register and sequencing
  // ----------------------------------------------------------------
  fsps_pkg::fsps_state_e state;
  logic [7:0] self_prog_ctrl_status;
  logic [2:0] arm_cnt;
  logic [31:0] op_cnt;
  logic [15:0] latched_page;
  logic op_is_write;
  logic op_no_read_while_write_section;
  logic rww_busy_flag;
  logic [4:0] cmd;
  logic self_prog_enable_bit;
  assign cmd = self_prog_ctrl_status[4:0];
  assign self_prog_enable_bit = self_prog_ctrl_status[fsps_pkg::CTL_ENABLE_BIT];

  // temporary page buffer; valid bits allow any load order
  logic [15:0] page_buf [WORDS];
  logic [WORDS-1:0] buf_valid;
  logic buf_clear;
  logic load_go;
  logic start_op;
  logic store_now;
  // store only counts while armed and within the window
  assign store_now = (state == fsps_pkg::FSPS_ARMED) && bus.spm_exec;
  assign load_go = store_now && (cmd == fsps_pkg::CMD_LOAD);
  assign start_op = store_now && ((cmd == fsps_pkg::CMD_ERASE) || (cmd == fsps_pkg::CMD_WRITE));
  // write-to-buffer auto erase, reenable write, eeprom collision
  assign buf_clear = (state == fsps_pkg::FSPS_DONE && op_is_write)
    || (store_now && cmd == fsps_pkg::CMD_REENABLE)
    || (bus.eeprom_write && |buf_valid);

  // main sequencer; eeprom write blocks arming entirely
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= fsps_pkg::FSPS_IDLE;
      self_prog_ctrl_status <= fsps_pkg::CTL_RESET;
      arm_cnt <= 3'h0;
      op_cnt <= 32'h0;
    end else if (ce_i) begin
      case (state)
        fsps_pkg::FSPS_IDLE: begin
          if (bus.ctl_we) begin
            self_prog_ctrl_status[fsps_pkg::CTL_INT_EN_BIT] <= bus.ctl_wdata[fsps_pkg::CTL_INT_EN_BIT];
            if (bus.ctl_wdata[fsps_pkg::CTL_ENABLE_BIT] && !bus.eeprom_write) begin
              self_prog_ctrl_status[4:0] <= bus.ctl_wdata[4:0];
              arm_cnt <= 3'h0;
              state <= fsps_pkg::FSPS_ARMED;
            end
          end
        end
        fsps_pkg::FSPS_ARMED: begin
          arm_cnt <= arm_cnt + 3'h1;
          if (start_op) begin
            op_cnt <= 32'h0;
            state <= fsps_pkg::FSPS_BUSY;
          end else if (store_now) begin
            state <= fsps_pkg::FSPS_DONE;
          end else if (arm_cnt == fsps_pkg::ARM_WINDOW - 3'h1) begin
            self_prog_ctrl_status[4:0] <= 5'h00;
            state <= fsps_pkg::FSPS_IDLE;
          end
        end
        fsps_pkg::FSPS_BUSY: begin
          op_cnt <= op_cnt + 32'h1;
          if (op_cnt == PROG_CYCLES - 1) begin
            state <= fsps_pkg::FSPS_DONE;
          end
        end
        fsps_pkg::FSPS_DONE: begin
          self_prog_ctrl_status[4:0] <= 5'h00;
          state <= fsps_pkg::FSPS_IDLE;
        end
        default: begin
          state <= fsps_pkg::FSPS_IDLE;
        end
      endcase
    end
  end

  // target latched at start so the pointer is free afterwards
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      latched_page <= 16'h0000;
      op_is_write <= 1'b0;
      op_no_read_while_write_section <= 1'b0;
    end else if (ce_i && start_op) begin
      latched_page <= page_select_field;
      op_is_write <= (cmd == fsps_pkg::CMD_WRITE);
      // pointer is a byte address; compare its word address with the word start
      op_no_read_while_write_section <= ({1'b0, page_select_field[15:1]} >= NO_READ_WHILE_WRITE_SECTION_START);
    end
  end

  // busy flag set with any erase/write, cleared by reenable after done
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rww_busy_flag <= 1'b0;
    end else if (ce_i) begin
      // either section as target blocks the rww section for reading
      if (start_op) begin
        rww_busy_flag <= 1'b1;
      end else if (store_now && cmd == fsps_pkg::CMD_REENABLE && state != fsps_pkg::FSPS_BUSY) begin
        rww_busy_flag <= 1'b0;
      end
    end
  end

  // buffer store, clear takes priority over a load in the same cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      buf_valid <= '0;
    end else if (ce_i) begin
      if (buf_clear) begin
        buf_valid <= '0;
      end else if (load_go) begin
        buf_valid[word_in_page_field] <= 1'b1;
        page_buf[word_in_page_field] <= bus.data_word;
      end
    end
  end

  // fuse pin through two flops; no reset, so the level is settled at release
  logic fuse_meta;
  logic fuse_sync;
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      fuse_meta <= boot_reset_select_fuse_i;
      fuse_sync <= fuse_meta;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_page_addr_o <= 16'h0000;
      flash_data_o <= 16'h0000;
      flash_word_o <= '0;
      buf_valid_o <= 1'b0;
      lock_set_o <= 1'b0;
      lock_data_o <= 8'h00;
      lpm_byte_addr_o <= 16'h0000;
      bus.cpu_halt <= 1'b0;
      bus.rww_blocked <= 1'b0;
      bus.spm_irq <= 1'b0;
      bus.ctl_rdata <= fsps_pkg::CTL_RESET;
      bus.reset_vector <= fsps_pkg::APP_RESET_ADDR;
    end else if (ce_i) begin
      // fuse is only an input; no path lets the cpu write it
      bus.reset_vector <= fuse_sync ? fsps_pkg::APP_RESET_ADDR : fsps_pkg::BOOT_RESET_ADDR;
      flash_erase_o <= (state == fsps_pkg::FSPS_BUSY) && !op_is_write;
      flash_write_o <= (state == fsps_pkg::FSPS_BUSY) && op_is_write;
      flash_page_addr_o <= latched_page;
      flash_word_o <= op_cnt[PAGE_LOG2-1:0];
      flash_data_o <= page_buf[op_cnt[PAGE_LOG2-1:0]];
      buf_valid_o <= buf_valid[op_cnt[PAGE_LOG2-1:0]];
      // lock set takes only r0; the pointer is never looked at
      lock_set_o <= store_now && (cmd == fsps_pkg::CMD_LOCKSET);
      lock_data_o <= bus.data_word[7:0];
      lpm_byte_addr_o <= lpm_addr_i;
      bus.cpu_halt <= (state == fsps_pkg::FSPS_BUSY) && op_no_read_while_write_section;
      bus.rww_blocked <= rww_busy_flag;
      bus.spm_irq <= self_prog_ctrl_status[fsps_pkg::CTL_INT_EN_BIT] && !self_prog_enable_bit;
      bus.ctl_rdata <= {self_prog_ctrl_status[7], rww_busy_flag, self_prog_ctrl_status[5:0]};
    end
  end
endmodule

// ==== src/fsps_boot_host.sv ====
// boot loader end: issues arm-then-store sequences to the sequencer
`timescale 1ns/1ps
module fsps_boot_host (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  fsps_if.host bus,
  input wire logic req_i,
  input wire logic [4:0] req_cmd_i,
  input wire logic req_int_en_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_data_i,
  input wire logic eeprom_write_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] status_o
);
  // ----------------------------------------------------------------
  // arm, store one cycle later, then poll the enable bit
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FSPS_H_IDLE = 3'b001,
    FSPS_H_STORE = 3'b010,
    FSPS_H_POLL = 3'b100
  } fsps_hstate_e;
  fsps_hstate_e hstate;

  // store lands well inside the four cycle window
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hstate <= FSPS_H_IDLE;
      bus.ctl_we <= 1'b0;
      bus.ctl_wdata <= 8'h00;
      bus.spm_exec <= 1'b0;
      bus.ptr_high <= 8'h00;
      bus.ptr_low <= 8'h00;
      bus.data_word <= 16'h0000;
      bus.eeprom_write <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      status_o <= 8'h00;
    end else if (ce_i) begin
      bus.ctl_we <= 1'b0;
      bus.spm_exec <= 1'b0;
      done_o <= 1'b0;
      bus.eeprom_write <= eeprom_write_i;
      status_o <= bus.ctl_rdata;
      case (hstate)
        FSPS_H_IDLE: begin
          if (req_i) begin
            // caller keeps erase and write on one page, erase first
            bus.ptr_high <= req_addr_i[15:8];
            bus.ptr_low <= req_addr_i[7:0];
            bus.data_word <= req_data_i;
            bus.ctl_wdata <= {req_int_en_i, 2'b00, req_cmd_i};
            bus.ctl_we <= 1'b1;
            busy_o <= 1'b1;
            hstate <= FSPS_H_STORE;
          end
        end
        FSPS_H_STORE: begin
          bus.spm_exec <= 1'b1;
          hstate <= FSPS_H_POLL;
        end
        FSPS_H_POLL: begin
          // wait one cycle of margin via registered status
          if (!bus.spm_exec && !bus.ctl_rdata[fsps_pkg::CTL_ENABLE_BIT] && !bus.cpu_halt) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            hstate <= FSPS_H_IDLE;
          end
        end
        default: begin
          hstate <= FSPS_H_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== dv/fsps_sva.sv ====
// concurrent checks on the interface between boot host and sequencer
`timescale 1ns/1ps
module fsps_sva (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ctl_we,
  input wire logic [7:0] ctl_rdata,
  input wire logic spm_exec,
  input wire logic cpu_halt,
  input wire logic rww_blocked,
  input wire logic spm_irq,
  input wire logic [15:0] reset_vector
);
  // longest erase or write, with margin over the bench program time of 64
  localparam int OP_MAX = 70;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // -------------------------------------------------
  // helper: cycles since the last control write
  // -------------------------------------------------
  logic [3:0] since_we;
  // saturates so a long idle stretch never wraps back into the window
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      since_we <= 4'hf;
    end else if (ctl_we) begin
      since_we <= 4'h0;
    end else if (since_we != 4'hf) begin
      since_we <= since_we + 4'h1;
    end
  end
  // -------------------------------------------------
  // sequences and assertions
  // -------------------------------------------------
  // status read-back lags the arming by a cycle, so look one cycle after the store
  sequence op_start;
    spm_exec ##1 (ctl_rdata[0] && ctl_rdata[2:1] != 2'h0);
  endsequence
  sequence load_start;
    spm_exec ##1 (ctl_rdata[4:0] == 5'h01);
  endsequence
  chk_block_on_op: assert property (op_start |-> ##1 rww_blocked)
    else $error("rww section not blocked at operation start");
  chk_block_in_halt: assert property (cpu_halt |-> rww_blocked)
    else $error("cpu halted but rww section not blocked");
  chk_exec_window: assert property (spm_exec |-> since_we <= 4'h3)
    else $error("store outside the arming window");
  chk_op_done: assert property (op_start |-> ##[1:OP_MAX] !ctl_rdata[0])
    else $error("enable bit not cleared after erase or write");
  chk_load_done: assert property (load_start |-> ##[1:4] !ctl_rdata[0])
    else $error("enable bit not cleared after load");
  chk_irq_on: assert property ((ctl_rdata[7] && !ctl_rdata[0]) [*3] |-> spm_irq)
    else $error("interrupt missing while enable bit clear");
  chk_irq_off: assert property ((!ctl_rdata[7]) [*3] |-> !spm_irq)
    else $error("interrupt raised while disabled");
  chk_busy_flag: assert property (rww_blocked && $past(rww_blocked) |-> ctl_rdata[6])
    else $error("busy flag low while section blocked");
  chk_halt_in_op: assert property (cpu_halt |-> ctl_rdata[0] || $past(ctl_rdata[0]))
    else $error("cpu halted outside an operation");
  chk_vector_value: assert property (reset_vector == 16'h0000 || reset_vector == fsps_pkg::BOOT_RESET_ADDR)
    else $error("reset vector neither application nor boot");
  chk_vector_fixed: assert property ($past(reset_n_i, 3) |-> $stable(reset_vector))
    else $error("reset vector changed while running");
endmodule

// ==== dv/fsps_sequencer_tb.sv ====
// self-checking bench: boot host end and sequencer end joined by the interface
`timescale 1ns/1ps
module fsps_sequencer_tb;
  // one full buffer walk per operation needs at least 64 cycles
  localparam int unsigned PC = 64;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic fuse = 1'b1;
  logic [15:0] lpm_addr = 16'h0000;
  logic req = 1'b0;
  logic [4:0] cmd = 5'h00;
  logic ien = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] data = 16'h0000;
  logic ee = 1'b0;
  logic ce = 1'b1;
  logic busy, done, ferase, fwrite, bvalid, lset;
  logic [7:0] status, ldata, lock_got;
  logic [15:0] lpm_out, fpage, fdata;
  logic [5:0] fword;
  int n_mismatch = 0;
  int n_checks = 0;
  int mbuf [64];
  bit mval [64];
  bit seen [64];
  int n_seen, halt_seen, blk_seen, lock_seen, r0;
  fsps_if bus ();
  fsps_sequencer #(.PROG_CYCLES(PC)) u_fsps_sequencer (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .bus(bus), .boot_reset_select_fuse_i(fuse), .lpm_addr_i(lpm_addr), .lpm_byte_addr_o(lpm_out),
    .flash_erase_o(ferase), .flash_write_o(fwrite), .flash_page_addr_o(fpage), .flash_data_o(fdata),
    .flash_word_o(fword), .buf_valid_o(bvalid), .lock_set_o(lset), .lock_data_o(ldata));
  fsps_boot_host u_fsps_boot_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .bus(bus),
    .req_i(req), .req_cmd_i(cmd), .req_int_en_i(ien), .req_addr_i(addr), .req_data_i(data),
    .eeprom_write_i(ee), .busy_o(busy), .done_o(done), .status_o(status));
  fsps_sva u_fsps_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .ctl_we(bus.ctl_we), .ctl_rdata(bus.ctl_rdata),
    .spm_exec(bus.spm_exec), .cpu_halt(bus.cpu_halt), .rww_blocked(bus.rww_blocked), .spm_irq(bus.spm_irq),
    .reset_vector(bus.reset_vector));
  // free-running 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // -------------------------------------------------
  // comparison, verdict, model upkeep
  // -------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // the buffer is emptied by write, reenable and reset alike
  task automatic clear_model();
    for (int i = 0; i < 64; i++) begin
      mval[i] = 1'b0;
      mbuf[i] = 0;
    end
  endtask
  // one host request, then a bounded wait for its completion pulse
  task automatic op(input logic [4:0] c, input logic [15:0] a, input logic [15:0] d, input logic ie);
    int k;
    @(negedge clk_i);
    req = 1'b1;
    cmd = c;
    addr = a;
    data = d;
    ien = ie;
    @(negedge clk_i);
    req = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 200) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic ld(input logic [15:0] a, input logic [15:0] d);
    op(fsps_pkg::CMD_LOAD, a, d, 1'b0);
    mbuf[a[6:1]] = int'(d);
    mval[a[6:1]] = 1'b1;
  endtask
  // page write: every loaded word, and only those, leaves the buffer
  task automatic wr(input logic [15:0] a);
    int cnt;
    cnt = 0;
    n_seen = 0;
    for (int i = 0; i < 64; i++) begin
      seen[i] = 1'b0;
      cnt += int'(mval[i]);
    end
    op(fsps_pkg::CMD_ERASE, a, 16'h0000, 1'b0);
    // interrupt on; nothing here fetches from the blocked section
    op(fsps_pkg::CMD_WRITE, a, 16'h0000, 1'b1);
    repeat (3) @(negedge clk_i);
    check(n_seen, cnt);
    check(bus.spm_irq, 1'b1);
    clear_model();
  endtask
  // watch the buffer walk, halt, block and lock pulses; mid-cycle, where they are settled
  always @(negedge clk_i) begin
    if (fwrite === 1'b1 && bvalid === 1'b1 && !seen[fword]) begin
      seen[fword] = 1'b1;
      n_seen++;
      check(mval[fword], 1'b1);
      check(fdata, mbuf[fword]);
    end
    if (bus.cpu_halt === 1'b1) halt_seen = 1;
    if (bus.rww_blocked === 1'b1) blk_seen = 1;
    if (lset === 1'b1) begin
      lock_seen = 1;
      lock_got = ldata;
    end
  end
  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial begin
    void'($urandom(88));
    clear_model();
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check(bus.reset_vector, 16'h0000);
    // scattered word order; distinct slots since a slot is loaded once
    r0 = $urandom_range(63);
    for (int i = 0; i < 6; i++) ld(16'h0100 | 16'(((r0 + i * 37) % 64) << 1), 16'($urandom));
    check(bus.spm_irq, 1'b0);
    halt_seen = 0;
    blk_seen = 0;
    op(fsps_pkg::CMD_ERASE, 16'h0100, 16'($urandom), 1'b0);
    repeat (2) @(negedge clk_i);
    check(halt_seen, 0);
    check(blk_seen, 1);
    check(status[6], 1'b1);
    wr(16'h0100);
    wr(16'h0100);
    ld(16'h0100 | 16'h0006, 16'($urandom));
    op(fsps_pkg::CMD_REENABLE, 16'h0000, 16'h0000, 1'b0);
    clear_model();
    repeat (3) @(negedge clk_i);
    check(status[6], 1'b0);
    wr(16'h0100);
    halt_seen = 0;
    op(fsps_pkg::CMD_ERASE, 16'hfe00, 16'h0000, 1'b0);
    check(halt_seen, 1);
    // eeprom write in mid-loading drops what was loaded so far
    ld(16'h0102, 16'($urandom));
    ld(16'h0110, 16'($urandom));
    @(negedge clk_i);
    ee = 1'b1;
    repeat (3) @(negedge clk_i);
    ee = 1'b0;
    clear_model();
    ld(16'h0120, 16'($urandom));
    wr(16'h0100);
    lock_seen = 0;
    data = 16'($urandom);
    op(fsps_pkg::CMD_LOCKSET, 16'($urandom), data, 1'b0);
    check(lock_seen, 1);
    check(lock_got, data[7:0]);
    for (int i = 0; i < 4; i++) begin
      lpm_addr = 16'($urandom);
      repeat (2) @(negedge clk_i);
      check(lpm_out, lpm_addr);
    end
    // clock enable low freezes every register
    ce = 1'b0;
    lpm_addr = lpm_addr ^ 16'hffff;
    repeat (3) @(negedge clk_i);
    check(lpm_out, lpm_addr ^ 16'hffff);
    ce = 1'b1;
    repeat (2) @(negedge clk_i);
    check(lpm_out, lpm_addr);
    // a word left in the buffer must not survive the reset
    ld(16'h0104, 16'($urandom));
    reset_n_i = 1'b0;
    fuse = 1'b0;
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check(bus.reset_vector, fsps_pkg::BOOT_RESET_ADDR);
    clear_model();
    wr(16'h0100);
    stop_test();
  end
endmodule
